// ---- shared/branch_pkg.sv ----
// Contract
// - Relative branch: 4 cycles taken, 3 not.
// - Single-flag branches test one flag, both senses.
// - Unsigned branches use carry OR zero.
// - Signed branches use V xor N, or Z.
// - Far indirect jump loads PC word, bank from +2.
// - Near indirect call: push return, then read target.
// - Near immediate and vector calls push one word.
// - Far calls push 32 bits; indirect reads 32.
package branch_pkg;

   // Relative branch lengths in core clocks
   localparam int REL_TAKEN_CYC = 4;
   localparam int REL_FALL_CYC = 3;

   // Register offsets, byte addresses
   localparam logic [7:0] REG_SP = 8'h00;
   localparam logic [7:0] REG_PC = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;

   // Reset values and the fixed stack bank
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] BANK_RESET = 8'h00;
   localparam logic [7:0] STACK_BANK = 8'h00;

   // Field positions
   localparam int PC_LSB = 0;
   localparam int BANK_LSB = 16;
   localparam int STAT_BUSY = 0;
   localparam int STAT_TAKEN = 1;
   localparam int STAT_STATE_LSB = 4;

   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [23:0] HI_OFFSET = 24'h000002;

   typedef enum logic [3:0] {
      OP_REL_COND = 4'h0,
      OP_REL_ALWAYS = 4'h1,
      OP_JMP_NEAR = 4'h2,
      OP_FAR_JUMP_IND = 4'h3,
      OP_FAR_JUMP_IMM = 4'h4,
      OP_CALL_NEAR_IND = 4'h5,
      OP_CALL_NEAR_IMM = 4'h6,
      OP_VECTOR_CALL = 4'h7,
      OP_FAR_CALL_IND = 4'h8,
      OP_FAR_CALL_IMM = 4'h9
   } op_e;

   typedef enum logic [3:0] {
      branch_if_zero_set = 4'h0,
      branch_if_zero_clear = 4'h1,
      branch_if_carry_set = 4'h2,
      branch_if_carry_clear = 4'h3,
      branch_if_neg_set = 4'h4,
      branch_if_neg_clear = 4'h5,
      branch_if_ovf_set = 4'h6,
      branch_if_ovf_clear = 4'h7,
      branch_if_sticky_set = 4'h8,
      branch_if_sticky_clear = 4'h9,
      branch_signed_less = 4'hA,
      branch_signed_greater_equal = 4'hB,
      branch_signed_less_equal = 4'hC,
      branch_signed_greater = 4'hD,
      branch_unsigned_lower_same = 4'hE,
      branch_unsigned_higher = 4'hF
   } cond_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_REL = 3'b001,
      ST_PUSH_HI = 3'b010,
      ST_PUSH_LO = 3'b011,
      ST_READ_LO = 3'b100,
      ST_READ_HI = 3'b101
   } state_e;

   typedef struct packed {
      op_e op;
      cond_e cond;
      logic [23:0] operand;
      logic [15:0] next_pc;
   } issue_s;

   typedef struct packed {
      logic z;
      logic c;
      logic n;
      logic v;
      logic t;
   } flags_s;

   typedef struct packed {
      logic req;
      logic we;
      logic [23:0] addr;
      logic [15:0] wdata;
   } mem_s;

endpackage

// ---- design/branch_cond_eval.sv ----
`timescale 1ns/1ps
module branch_cond_eval (
   // Condition select and flags
   input wire branch_pkg::cond_e cond,
   input wire branch_pkg::flags_s flags,
   // Result
   output logic taken
);

   wire signed_lt = flags.v ^ flags.n;
   wire signed_le = signed_lt | flags.z;
   wire unsigned_ls = flags.c | flags.z;

   always_comb begin
      unique case (cond)
         branch_pkg::branch_if_zero_set: taken = flags.z;
         branch_pkg::branch_if_zero_clear: taken = ~flags.z;
         branch_pkg::branch_if_carry_set: taken = flags.c;
         branch_pkg::branch_if_carry_clear: taken = ~flags.c;
         branch_pkg::branch_if_neg_set: taken = flags.n;
         branch_pkg::branch_if_neg_clear: taken = ~flags.n;
         branch_pkg::branch_if_ovf_set: taken = flags.v;
         branch_pkg::branch_if_ovf_clear: taken = ~flags.v;
         branch_pkg::branch_if_sticky_set: taken = flags.t;
         branch_pkg::branch_if_sticky_clear: taken = ~flags.t;
         branch_pkg::branch_signed_less: taken = signed_lt;
         branch_pkg::branch_signed_greater_equal: taken = ~signed_lt;
         branch_pkg::branch_signed_less_equal: taken = signed_le;
         branch_pkg::branch_signed_greater: taken = ~signed_le;
         branch_pkg::branch_unsigned_lower_same: taken = unsigned_ls;
         branch_pkg::branch_unsigned_higher: taken = ~unsigned_ls;
      endcase
   end

endmodule // branch_cond_eval

// ---- design/branch_flow_control.sv ----
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module branch_flow_control (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Instruction issue from decode
   input wire logic issue_valid,
   input wire branch_pkg::issue_s issue,
   input wire branch_pkg::flags_s flags,
   output logic issue_ready_q,
   output logic done_q,
   // Program counter and bank
   output logic [15:0] pc_q,
   output logic [7:0] bank_q,
   // Memory bus for stack and operands
   output branch_pkg::mem_s mem_q,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q
);

   localparam logic [1:0] TAKEN_LOAD = 2'(branch_pkg::REL_TAKEN_CYC - 3);
   localparam logic [1:0] FALL_LOAD = 2'(branch_pkg::REL_FALL_CYC - 3);

   branch_pkg::state_e state_q, state_d;
   logic [1:0] cnt_q, cnt_d;
   logic [15:0] sp_q, sp_d;
   logic [15:0] pc_d;
   logic [7:0] bank_d;
   logic [15:0] ret_q, ret_d;
   logic [23:0] tgt_q, tgt_d;
   logic [15:0] tgt_lo_q, tgt_lo_d;
   logic far_q, far_d;
   logic read_q, read_d;
   logic taken_q, taken_d;
   logic done_d;
   branch_pkg::mem_s mem_d;
   logic [31:0] rdata_d;
   logic cond_taken;

   branch_cond_eval u_cond (
      .cond(issue.cond),
      .flags(flags),
      .taken(cond_taken)
   );

   // Op class decode, kept beside the wires that lean on it
   function automatic logic is_rel(input branch_pkg::op_e op);
      return (op == branch_pkg::OP_REL_COND) || (op == branch_pkg::OP_REL_ALWAYS);
   endfunction

   function automatic logic is_far_call(input branch_pkg::op_e op);
      return (op == branch_pkg::OP_FAR_CALL_IND) || (op == branch_pkg::OP_FAR_CALL_IMM);
   endfunction

   function automatic logic is_near_call(input branch_pkg::op_e op);
      return (op == branch_pkg::OP_CALL_NEAR_IND) || (op == branch_pkg::OP_CALL_NEAR_IMM) ||
         (op == branch_pkg::OP_VECTOR_CALL);
   endfunction

   function automatic logic reads_target(input branch_pkg::op_e op);
      return (op == branch_pkg::OP_CALL_NEAR_IND) || (op == branch_pkg::OP_FAR_CALL_IND) ||
         (op == branch_pkg::OP_FAR_JUMP_IND);
   endfunction

   // Status layout in one place so software and sequencer agree
   function automatic logic [31:0] status_of(input branch_pkg::state_e st, input logic tk);
      logic [31:0] w;
      w = 32'h0;
      w[branch_pkg::STAT_BUSY] = st != branch_pkg::ST_IDLE;
      w[branch_pkg::STAT_TAKEN] = tk;
      w[branch_pkg::STAT_STATE_LSB +: 3] = st;
      return w;
   endfunction

   // Ready gates the accept too, so nothing slips in on the edge after reset
   wire accept = issue_valid && issue_ready_q && (state_q == branch_pkg::ST_IDLE);
   wire rel_op = is_rel(issue.op);
   wire rel_taken = (issue.op == branch_pkg::OP_REL_ALWAYS) || cond_taken;
   wire [15:0] rel_target = issue.next_pc + {{8{issue.operand[7]}}, issue.operand[7:0]};
   wire far_call = is_far_call(issue.op);
   wire near_push = is_near_call(issue.op);
   wire ind_read = reads_target(issue.op);
   wire far_load = far_call || (issue.op == branch_pkg::OP_FAR_JUMP_IND);
   wire bus_active = mem_q.req && mem_ack;
   wire entering = state_d != state_q;
   wire push_enter = entering &&
      (state_d == branch_pkg::ST_PUSH_HI || state_d == branch_pkg::ST_PUSH_LO);
   wire sp_wr = reg_wr && (reg_addr == branch_pkg::REG_SP);
   wire pc_wr = reg_wr && (reg_addr == branch_pkg::REG_PC);
   wire [31:0] status_word = status_of(state_q, taken_q);

   // Sequencer
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      pc_d = pc_q;
      bank_d = bank_q;
      ret_d = ret_q;
      tgt_d = tgt_q;
      tgt_lo_d = tgt_lo_q;
      far_d = far_q;
      read_d = read_q;
      taken_d = taken_q;
      done_d = 1'b0;
      unique case (state_q)
         branch_pkg::ST_IDLE: begin
            if (accept) begin
               ret_d = issue.next_pc;
               tgt_d = issue.operand;
               far_d = far_load;
               read_d = ind_read;
               unique case (issue.op)
                  branch_pkg::OP_REL_COND, branch_pkg::OP_REL_ALWAYS: begin
                     taken_d = rel_taken;
                     cnt_d = rel_taken ? TAKEN_LOAD : FALL_LOAD;
                     state_d = branch_pkg::ST_REL;
                  end
                  branch_pkg::OP_JMP_NEAR: begin
                     pc_d = issue.operand[15:0];
                     done_d = 1'b1;
                  end
                  branch_pkg::OP_FAR_JUMP_IMM: begin
                     pc_d = issue.operand[15:0];
                     bank_d = issue.operand[23:16];
                     done_d = 1'b1;
                  end
                  branch_pkg::OP_FAR_JUMP_IND: state_d = branch_pkg::ST_READ_LO;
                  branch_pkg::OP_FAR_CALL_IND, branch_pkg::OP_FAR_CALL_IMM:
                     state_d = branch_pkg::ST_PUSH_HI;
                  default: begin
                     // Near calls go to the low-word push; codes outside the op set retire at once, never touching the stack
                     if (near_push) begin
                        state_d = branch_pkg::ST_PUSH_LO;
                     end else begin
                        done_d = 1'b1;
                     end
                  end
               endcase
            end
         end
         branch_pkg::ST_REL: begin
            if (cnt_q == 2'h0) begin
               if (taken_q) begin
                  pc_d = tgt_q[15:0];
               end else begin
                  pc_d = ret_q;
               end
               done_d = 1'b1;
               state_d = branch_pkg::ST_IDLE;
            end else begin
               cnt_d = cnt_q - 2'h1;
            end
         end
         branch_pkg::ST_PUSH_HI: begin
            if (bus_active) begin
               state_d = branch_pkg::ST_PUSH_LO;
            end
         end
         branch_pkg::ST_PUSH_LO: begin
            if (bus_active) begin
               if (read_q) begin
                  state_d = branch_pkg::ST_READ_LO;
               end else begin
                  pc_d = tgt_q[15:0];
                  if (far_q) begin
                     bank_d = tgt_q[23:16];
                  end
                  done_d = 1'b1;
                  state_d = branch_pkg::ST_IDLE;
               end
            end
         end
         branch_pkg::ST_READ_LO: begin
            if (bus_active) begin
               if (far_q) begin
                  tgt_lo_d = mem_rdata;
                  state_d = branch_pkg::ST_READ_HI;
               end else begin
                  pc_d = mem_rdata;
                  done_d = 1'b1;
                  state_d = branch_pkg::ST_IDLE;
               end
            end
         end
         branch_pkg::ST_READ_HI: begin
            if (bus_active) begin
               pc_d = tgt_lo_q;
               bank_d = mem_rdata[7:0];
               done_d = 1'b1;
               state_d = branch_pkg::ST_IDLE;
            end
         end
         default: state_d = branch_pkg::ST_IDLE;
      endcase
      // Software load of the PC only while idle, so a transfer never gets torn
      if (pc_wr && state_q == branch_pkg::ST_IDLE && !accept) begin
         pc_d = reg_wdata[branch_pkg::PC_LSB +: 16];
         bank_d = reg_wdata[branch_pkg::BANK_LSB +: 8];
      end
   end

   // Stack pointer: a push owns it over a software write
   assign sp_d = push_enter ? sp_q - branch_pkg::WORD_STEP :
      (sp_wr ? reg_wdata[15:0] : sp_q);

   // Bus request follows the next state so it leaves a flop
   always_comb begin
      mem_d = '0;
      unique case (state_d)
         branch_pkg::ST_PUSH_HI: begin
            mem_d.req = 1'b1;
            mem_d.we = 1'b1;
            mem_d.addr = {branch_pkg::STACK_BANK, sp_d};
            mem_d.wdata = {8'h00, bank_q};
         end
         branch_pkg::ST_PUSH_LO: begin
            mem_d.req = 1'b1;
            mem_d.we = 1'b1;
            mem_d.addr = {branch_pkg::STACK_BANK, sp_d};
            mem_d.wdata = ret_d;
         end
         branch_pkg::ST_READ_LO: begin
            mem_d.req = 1'b1;
            mem_d.addr = tgt_d;
         end
         branch_pkg::ST_READ_HI: begin
            mem_d.req = 1'b1;
            mem_d.addr = tgt_d + branch_pkg::HI_OFFSET;
         end
         default: mem_d = '0;
      endcase
      // A stalled request stands untouched, even if software moves the SP meanwhile
      if (mem_q.req && !bus_active) begin
         mem_d = mem_q;
      end
   end

   assign rdata_d = !reg_rd ? 32'h0 :
      (reg_addr == branch_pkg::REG_SP) ? {16'h0, sp_q} :
      (reg_addr == branch_pkg::REG_PC) ? {8'h0, bank_q, pc_q} :
      (reg_addr == branch_pkg::REG_STATUS) ? status_word : 32'h0;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= branch_pkg::ST_IDLE;
         cnt_q <= 2'h0;
         sp_q <= branch_pkg::SP_RESET;
         pc_q <= branch_pkg::PC_RESET;
         bank_q <= branch_pkg::BANK_RESET;
         ret_q <= 16'h0000;
         tgt_q <= 24'h000000;
         tgt_lo_q <= 16'h0000;
         far_q <= 1'b0;
         read_q <= 1'b0;
         taken_q <= 1'b0;
         done_q <= 1'b0;
         issue_ready_q <= 1'b0;
         mem_q <= '0;
         reg_rdata_q <= 32'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sp_q <= sp_d;
         pc_q <= pc_d;
         bank_q <= bank_d;
         ret_q <= ret_d;
         tgt_q <= (state_q == branch_pkg::ST_IDLE && accept && rel_op) ?
            {8'h00, rel_target} : tgt_d;
         tgt_lo_q <= tgt_lo_d;
         far_q <= far_d;
         read_q <= read_d;
         taken_q <= taken_d;
         done_q <= done_d;
         issue_ready_q <= state_d == branch_pkg::ST_IDLE;
         mem_q <= mem_d;
         reg_rdata_q <= rdata_d;
      end
   end

endmodule // branch_flow_control

// ---- test/mem_model.sv ----
`timescale 1ns/1ps
module mem_model (
   // Clock and bus
   input wire logic core_clk,
   input wire branch_pkg::mem_s mem_q,
   input wire logic [1:0] slow,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   logic [15:0] mem [0:255];
   logic [1:0] wait_q = 2'h0;
   logic [15:0] last_q = 16'h0;
   wire [7:0] idx = mem_q.addr[8:1];
   // Waits slow cycles before each ack
   assign mem_ack = mem_q.req && wait_q == slow;
   // Idle data inverts so a stale word cannot pass
   assign mem_rdata = mem_ack && !mem_q.we ? mem[idx] : ~last_q;
   // Plain always: the bench preloads the array from outside
   always @(posedge core_clk) begin
      wait_q <= mem_ack || !mem_q.req ? 2'h0 : wait_q + 2'h1;
      if (mem_ack) begin
         last_q <= mem_rdata;
      end
      if (mem_ack && mem_q.we) begin
         mem[idx] <= mem_q.wdata;
      end
   end
endmodule // mem_model

// ---- test/branch_flow_assertions.sv ----
`timescale 1ns/1ps
module branch_flow_assertions (
   // Clock, reset, issue
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic issue_valid,
   input wire branch_pkg::issue_s issue,
   input wire branch_pkg::flags_s flags,
   input wire logic issue_ready_q,
   input wire logic done_q,
   // Results and bus
   input wire logic [15:0] pc_q,
   input wire logic [7:0] bank_q,
   input wire branch_pkg::mem_s mem_q
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   logic [23:0] opd_q;
   logic [15:0] nxt_q, tgt_q;
   logic [7:0] bnk_q;
   wire acc = issue_valid && issue_ready_q;
   wire rel = acc && issue.op == branch_pkg::OP_REL_ALWAYS;
   wire cz = acc && issue.op == branch_pkg::OP_REL_COND
      && issue.cond == branch_pkg::branch_if_zero_set;
   wire nearc = acc && issue.op inside {branch_pkg::OP_CALL_NEAR_IMM,
      branch_pkg::OP_VECTOR_CALL, branch_pkg::OP_CALL_NEAR_IND};
   wire farc = acc && issue.op inside {branch_pkg::OP_FAR_CALL_IMM,
      branch_pkg::OP_FAR_CALL_IND};
   always_ff @(posedge core_clk) begin
      if (acc) begin
         opd_q <= issue.operand;
         nxt_q <= issue.next_pc;
         tgt_q <= issue.next_pc + {{8{issue.operand[7]}}, issue.operand[7:0]};
         bnk_q <= bank_q;
      end
   end
   rel_len_a: assert property (rel |=> !done_q [*2] ##1 done_q)
      else $error("Taken branch length wrong");
   rel_tgt_a: assert property (rel |-> ##3 pc_q == tgt_q && bank_q == bnk_q)
      else $error("Relative target wrong");
   zero_fall_a: assert property (cz && !flags.z |-> ##2 done_q && pc_q == nxt_q)
      else $error("Fall-through wrong");
   zero_take_a: assert property (cz && flags.z |-> ##2 !done_q ##1 done_q)
      else $error("Zero branch not taken");
   ready_done_a: assert property (done_q |-> issue_ready_q)
      else $error("Ready late after done");
   far_imm_a: assert property (acc && issue.op == branch_pkg::OP_FAR_JUMP_IMM
      |=> done_q && {bank_q, pc_q} == opd_q)
      else $error("Far jump target wrong");
   far_ind_a: assert property (acc && issue.op == branch_pkg::OP_FAR_JUMP_IND
      |=> mem_q.req && !mem_q.we && mem_q.addr == opd_q)
      else $error("Far jump read wrong");
   near_push_a: assert property (nearc |=> mem_q.req && mem_q.we && mem_q.wdata == nxt_q)
      else $error("Near push wrong");
   far_push_a: assert property (farc |=> mem_q.we && mem_q.wdata == {8'h00, bank_q})
      else $error("Far push wrong");
   cover property (rel);
   cover property (cz && !flags.z);
   cover property (acc && issue.op == branch_pkg::OP_FAR_CALL_IND);
endmodule // branch_flow_assertions
bind branch_flow_control branch_flow_assertions u_branch_flow_assertions (
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .issue_valid(issue_valid),
   .issue(issue),
   .flags(flags),
   .issue_ready_q(issue_ready_q),
   .done_q(done_q),
   .pc_q(pc_q),
   .bank_q(bank_q),
   .mem_q(mem_q)
);

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   localparam logic [15:0] RET = 16'h1234;
   logic core_clk, sys_rst, issue_valid, issue_ready_q, done_q, mem_ack, reg_wr, reg_rd, tk;
   logic [1:0] slow;
   logic [7:0] reg_addr, bank_q, dsp;
   logic [15:0] pc_q, mem_rdata, e;
   logic [31:0] reg_wdata, reg_rdata_q, d;
   logic [4:0] pat [4] = '{5'h00, 5'h1F, 5'h0A, 5'h15};
   branch_pkg::issue_s issue;
   branch_pkg::flags_s flags;
   branch_pkg::mem_s mem_q;
   logic [40:0] log [$];
   int errors = 0;
   int n_checks = 0;
   int n, ec;
   branch_flow_control u_branch_flow_control (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .issue_valid(issue_valid),
      .issue(issue),
      .flags(flags),
      .issue_ready_q(issue_ready_q),
      .done_q(done_q),
      .pc_q(pc_q),
      .bank_q(bank_q),
      .mem_q(mem_q),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q)
   );
   mem_model u_mem_model (
      .core_clk(core_clk),
      .mem_q(mem_q),
      .slow(slow),
      .mem_ack(mem_ack),
      .mem_rdata(mem_rdata)
   );
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (mem_q.req && mem_ack) begin
         log.push_back({mem_q.we, mem_q.addr, mem_q.we ? mem_q.wdata : 16'h0});
      end
   end
   task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata_q;
   endtask
   // Issue one instruction and count cycles up to done
   task automatic go(input branch_pkg::op_e o, input logic [3:0] c, input logic [23:0] a,
         input logic [4:0] f);
      log.delete();
      @(posedge core_clk);
      issue <= '{o, branch_pkg::cond_e'(c), a, RET};
      flags <= f;
      issue_valid <= 1'b1;
      @(posedge core_clk);
      issue_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (done_q !== 1'b1 && n < 40);
   endtask
   task automatic bus(input logic we, input logic [15:0] a, input logic [15:0] v);
      logic [40:0] x;
      x = log.size() > 0 ? log.pop_front() : '1;
      chk("bus", x, {we, 8'h00, a, v});
   endtask
   function automatic logic exp_tk(input logic [3:0] c, input logic [4:0] f);
      logic [7:0] t;
      t = {f[3] | f[4], (f[1] ^ f[2]) | f[4], f[1] ^ f[2], f[0], f[1], f[2], f[3], f[4]};
      return t[c[3:1]] ^ c[0];
   endfunction
   initial begin
      sys_rst = 1'b1;
      issue_valid = 1'b0;
      issue = '0;
      flags = '0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      slow = 2'h0;
      u_mem_model.mem[8'h20] = 16'hBEEF;
      u_mem_model.mem[8'h21] = 16'hFF37;
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(negedge core_clk);
      wr(branch_pkg::REG_SP, 32'h0000_0100);
      rd(8'h0C);
      chk("unmapped", d, 32'h0);
      go(branch_pkg::OP_FAR_JUMP_IMM, 4'h0, 24'h5A4321, 5'h00);
      chk("jmp_cycles", n, 1);
      chk("jmp_dest", {bank_q, pc_q}, 24'h5A4321);
      go(branch_pkg::OP_JMP_NEAR, 4'h0, 24'h7E6789, 5'h00);
      chk("jmpn_cycles", n, 1);
      chk("jmpn_dest", {bank_q, pc_q}, 24'h5A6789);
      foreach (pat[i]) begin
         for (int c = 0; c < 16; c++) begin
            dsp = {c[3:0], 4'hC};
            go(branch_pkg::OP_REL_COND, c[3:0], {16'h0, dsp}, pat[i]);
            tk = exp_tk(c[3:0], pat[i]);
            e = tk ? RET + {{8{dsp[7]}}, dsp} : RET;
            ec = tk ? branch_pkg::REL_TAKEN_CYC : branch_pkg::REL_FALL_CYC;
            chk("cycles", n + 1, ec);
            chk("rel_pc", pc_q, e);
            chk("rel_bank", bank_q, 8'h5A);
         end
      end
      go(branch_pkg::OP_REL_ALWAYS, 4'h0, 24'h000080, 5'h1F);
      chk("bra_cycles", n, 3);
      chk("bra_pc", pc_q, 16'h11B4);
      rd(branch_pkg::REG_STATUS);
      chk("status", d, 32'h1 << branch_pkg::STAT_TAKEN);
      go(branch_pkg::OP_CALL_NEAR_IMM, 4'h0, 24'h002222, 5'h00);
      bus(1'b1, 16'h00FE, RET);
      chk("near_dest", {bank_q, pc_q}, 24'h5A2222);
      go(branch_pkg::OP_VECTOR_CALL, 4'h0, 24'h003333, 5'h00);
      bus(1'b1, 16'h00FC, RET);
      chk("vec_pc", pc_q, 16'h3333);
      rd(branch_pkg::REG_SP);
      chk("sp", d[15:0], 16'h00FC);
      // Slow bus from here on
      @(posedge core_clk);
      slow <= 2'h2;
      go(branch_pkg::OP_CALL_NEAR_IND, 4'h0, 24'h000040, 5'h00);
      bus(1'b1, 16'h00FA, RET);
      bus(1'b0, 16'h0040, 16'h0);
      chk("ind_pc", pc_q, 16'hBEEF);
      go(branch_pkg::OP_FAR_JUMP_IND, 4'h0, 24'h000040, 5'h00);
      bus(1'b0, 16'h0040, 16'h0);
      bus(1'b0, 16'h0042, 16'h0);
      chk("fji_dest", {bank_q, pc_q}, 24'h37BEEF);
      go(branch_pkg::OP_FAR_CALL_IMM, 4'h0, 24'h125555, 5'h00);
      bus(1'b1, 16'h00F8, 16'h0037);
      bus(1'b1, 16'h00F6, RET);
      chk("fci_dest", {bank_q, pc_q}, 24'h125555);
      go(branch_pkg::OP_FAR_CALL_IND, 4'h0, 24'h000040, 5'h00);
      bus(1'b1, 16'h00F4, 16'h0012);
      bus(1'b1, 16'h00F2, RET);
      bus(1'b0, 16'h0040, 16'h0);
      bus(1'b0, 16'h0042, 16'h0);
      rd(branch_pkg::REG_PC);
      chk("pc_reg", d, 32'h0037BEEF);
      wrap_up();
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      errors++;
      wrap_up();
   end
endmodule // tb_top
